/* File: hdl/adcdc_core.sv */
// decimation filter, clock selection, reference control and bus sharing
// assumes modulator bits arrive from pins; master clock input sampled in CLK_I
`timescale 1ns/1ps
module adcdc_core
  import adcdc_pkg::*;
#(
  parameter int NCH   = ADCDC_NCH,
  parameter int DEPTH = 16
) (
  input  wire logic                     CLK_I,
  input  wire logic                     RST_I,
  input  wire logic                     CLOCK_SOURCE_SELECT_PIN_I,
  input  wire logic                     EXT_CLK_I,
  output logic                          CLK_PIN_O,
  output logic                          CLK_PIN_OE_O,
  input  wire adcdc_pkg::adcdc_cfg2_s   CFG2_I,
  input  wire logic                     CLK_RATE_SEL_I,
  input  wire logic [ADCDC_RATE_W-1:0]  OUTPUT_RATE_FIELD_I,
  output logic                          REF_HIGH_LEVEL_O,
  output logic                          REF_BUFFER_ON_O,
  output logic [23:0]                   REF_MV_O,
  input  wire logic [NCH-1:0]           MOD_BIT_I,
  input  wire logic                     START_I,
  output logic                          MOD_TICK_O,
  output logic                          RESULT_READY_STROBE_O,
  output logic [ADCDC_NCH*ADCDC_RES_W-1:0] RESULT_WORDS_O,
  output logic                          RESULT_VALID_O,
  input  wire logic                     RESULT_READY_I,
  output logic                          OVERRUN_O,
  input  wire logic                     CS_N_I,
  input  wire logic                     SCLK_I,
  output logic                          DOUT_O,
  output logic                          DOUT_OE_O
);
  import adcdc_pkg::*;

  // three-stage synchronisers for pin inputs
  logic [2:0] ext_s_q, st_s_q, cs_s_q, sck_s_q;
  logic [2:0] mb_s_q [NCH];
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ext_s_q <= '0;
      st_s_q  <= '0;
      cs_s_q  <= 3'h7;
      sck_s_q <= '0;
      for (int c = 0; c < NCH; c++) mb_s_q[c] <= '0;
    end else begin
      ext_s_q <= {ext_s_q[1:0], EXT_CLK_I};
      st_s_q  <= {st_s_q[1:0], START_I};
      cs_s_q  <= {cs_s_q[1:0], CS_N_I};
      sck_s_q <= {sck_s_q[1:0], SCLK_I};
      for (int c = 0; c < NCH; c++) mb_s_q[c] <= {mb_s_q[c][1:0], MOD_BIT_I[c]};
    end
  end

  // internal oscillator model: divider of the core clock
  logic [7:0] osc_cnt_q;
  logic       osc_q;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      osc_cnt_q <= '0;
      osc_q     <= 1'b0;
    end else if (osc_cnt_q == 8'(ADCDC_OSC_HALF - 1)) begin
      osc_cnt_q <= '0;
      osc_q     <= ~osc_q;
    end else begin
      osc_cnt_q <= osc_cnt_q + 8'h01;
    end
  end

  // clock source and pin direction
  logic internal_sel;
  assign internal_sel = CLOCK_SOURCE_SELECT_PIN_I;
  assign CLK_PIN_OE_O = internal_sel && CFG2_I.clk_out_enable;
  assign CLK_PIN_O    = internal_sel && CFG2_I.clk_out_enable && osc_q;

  // master clock rising edge, external edge counted when stage 2 is high and stage 3 still low
  logic ext_rise, osc_prev_q, mclk_rise;
  assign ext_rise = ext_s_q[1] && !ext_s_q[2];
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) osc_prev_q <= 1'b0;
    else       osc_prev_q <= osc_q;
  end
  assign mclk_rise = internal_sel ? (osc_q && !osc_prev_q) : ext_rise;

  // modulator divider: 4 at 512 kHz, 16 at 2.048 MHz, both giving 128 kHz
  logic       clk_rate_q;
  logic [3:0] mdiv_q;
  logic       mod_tick;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) clk_rate_q <= ADCDC_CLKDIV_RST;
    else       clk_rate_q <= CLK_RATE_SEL_I;
  end
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) mdiv_q <= '0;
    else if (mclk_rise) begin
      if (mdiv_q == 4'((clk_rate_q ? ADCDC_DIV_FAST : ADCDC_DIV_SLOW) - 1)) mdiv_q <= '0;
      else mdiv_q <= mdiv_q + 4'h1;
    end
  end
  assign mod_tick   = mclk_rise && (mdiv_q == 4'h0);
  assign MOD_TICK_O = mod_tick;

  // reference control
  assign REF_HIGH_LEVEL_O = CFG2_I.ref_high_level_select;
  assign REF_BUFFER_ON_O  = !CFG2_I.ref_buffer_power_down;
  assign REF_MV_O = CFG2_I.ref_high_level_select ? ADCDC_MV_REF_HI : ADCDC_MV_REF_LO;

  // start edge detection and shared decimation ratio
  logic         start_rise;
  logic [10:0]  ratio_q;
  assign start_rise = st_s_q[1] && !st_s_q[2];
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) ratio_q <= adcdc_ratio(ADCDC_RATE_RST);
    else if (start_rise) ratio_q <= adcdc_ratio(OUTPUT_RATE_FIELD_I);
  end

  // sinc3 integrators at modulator rate, combs at output rate
  localparam int AW = ADCDC_ACC_W;
  logic signed [AW-1:0] int1_q [NCH], int2_q [NCH], int3_q [NCH];
  logic signed [AW-1:0] d1_q [NCH], d2_q [NCH], d3_q [NCH];
  logic signed [AW-1:0] c1, c2, c3;
  logic [10:0]          phase_q;
  logic                 dec_tick;
  assign dec_tick = mod_tick && (phase_q == ratio_q - 11'h001);

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) phase_q <= '0;
    else if (start_rise) phase_q <= '0;
    else if (mod_tick) phase_q <= dec_tick ? 11'h000 : phase_q + 11'h001;
  end

  logic signed [AW-1:0] comb_out [NCH];
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      c1 = int3_q[c] - d1_q[c];
      c2 = c1 - d2_q[c];
      c3 = c2 - d3_q[c];
      comb_out[c] = c3;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int c = 0; c < NCH; c++) begin
        int1_q[c] <= '0; int2_q[c] <= '0; int3_q[c] <= '0;
        d1_q[c] <= '0; d2_q[c] <= '0; d3_q[c] <= '0;
      end
    end else if (start_rise) begin
      for (int c = 0; c < NCH; c++) begin
        int1_q[c] <= '0; int2_q[c] <= '0; int3_q[c] <= '0;
        d1_q[c] <= '0; d2_q[c] <= '0; d3_q[c] <= '0;
      end
    end else if (mod_tick) begin
      for (int c = 0; c < NCH; c++) begin
        // bit 1 -> +1, bit 0 -> -1
        int1_q[c] <= int1_q[c] + (mb_s_q[c][2] ? AW'(1) : -AW'(1));
        int2_q[c] <= int2_q[c] + int1_q[c];
        int3_q[c] <= int3_q[c] + int2_q[c];
        if (dec_tick) begin
          d1_q[c] <= int3_q[c];
          d2_q[c] <= int3_q[c] - d1_q[c];
          d3_q[c] <= int3_q[c] - d1_q[c] - d2_q[c];
        end
      end
    end
  end

  // scale N^3 full scale to 24 bits and clip
  function automatic logic [23:0] adcdc_scale(input logic signed [AW-1:0] v,
                                              input logic [10:0] n);
    logic signed [AW+23:0] p;
    logic [4:0]            sh;
    sh = 5'd0;
    for (int i = 0; i < 11; i++) if (n[i]) sh = 5'(3 * i);
    p = ($signed({{24{v[AW-1]}}, v}) <<< 23) >>> sh;
    if (p >= $signed({{(AW+1){1'b0}}, ADCDC_POS_FS[22:0]})) return ADCDC_POS_FS;
    if (p <= -$signed({{(AW+1){1'b0}}, ADCDC_POS_FS[22:0]})) return ADCDC_NEG_FS;
    return p[23:0];
  endfunction : adcdc_scale

  // settling: discard the first three decimated outputs after start
  adcdc_state_e st_q;
  logic [1:0]   drop_q;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q   <= ADCDC_IDLE;
      drop_q <= '0;
    end else if (start_rise) begin
      st_q   <= ADCDC_SETTLE;
      drop_q <= 2'(ADCDC_FLT_ORDER - 1);
    end else if (dec_tick) begin
      case (st_q)
        ADCDC_IDLE:   st_q <= ADCDC_IDLE;
        ADCDC_SETTLE: begin
          if (drop_q == 2'h0) st_q <= ADCDC_RUN;
          else drop_q <= drop_q - 2'h1;
        end
        ADCDC_RUN:    st_q <= ADCDC_RUN;
        default:      st_q <= ADCDC_IDLE;
      endcase
    end
  end

  // result word set and ready strobe
  adcdc_word_s word_d;
  logic        push;
  logic        fifo_in_ready;
  always_comb begin
    word_d.ch0 = adcdc_scale(comb_out[0], ratio_q);
    word_d.ch1 = adcdc_scale(comb_out[NCH-1], ratio_q);
  end
  assign push = dec_tick && (st_q == ADCDC_RUN);

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RESULT_READY_STROBE_O <= 1'b0;
      OVERRUN_O             <= 1'b0;
    end else begin
      RESULT_READY_STROBE_O <= push;
      OVERRUN_O             <= push && !fifo_in_ready;
    end
  end

  adcdc_word_s out_word;
  adcdc_fifo #(.W(ADCDC_NCH*ADCDC_RES_W), .DEPTH(DEPTH)) u_fifo (
    .clk_i       (CLK_I),
    .rst_i       (RST_I),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (word_d),
    .out_valid_o (RESULT_VALID_O),
    .out_ready_i (RESULT_READY_I),
    .out_data_o  (out_word)
  );
  assign RESULT_WORDS_O = out_word;

  // serial shift of the head word, MSB first; released while deselected
  logic [5:0]  bit_q;
  logic        cs_active, sck_fall;
  assign cs_active = !cs_s_q[2] && !cs_s_q[1];
  assign sck_fall  = !sck_s_q[1] && sck_s_q[2];
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) bit_q <= '0;
    else if (!cs_active) bit_q <= '0;
    else if (sck_fall && bit_q != 6'(ADCDC_NCH*ADCDC_RES_W - 1)) bit_q <= bit_q + 6'h01;
  end
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      DOUT_O    <= 1'b0;
      DOUT_OE_O <= 1'b0;
    end else begin
      DOUT_OE_O <= cs_active;
      DOUT_O    <= cs_active && out_word[6'(ADCDC_NCH*ADCDC_RES_W - 1) - bit_q];
    end
  end
endmodule : adcdc_core

/* File: hdl/adcdc_fifo.sv */
// synchronous valid/ready FIFO for result word sets
// assumes one clock, asynchronous active-high reset
`timescale 1ns/1ps
module adcdc_fifo #(
  parameter int W     = 48,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic         full;
  logic         empty;

  assign empty       = (wr_q == rd_q);
  assign full        = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rd_q[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (in_valid_i && !full) begin
      mem[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid_i && !full) wr_q <= wr_q + 1'b1;
      if (out_ready_i && !empty) rd_q <= rd_q + 1'b1;
    end
  end
endmodule : adcdc_fifo

/* File: hdl/adcdc_pkg.sv */
// constants, types and modes for the decimation and clock core
// assumes a 20 MHz core clock; analog reference levels are coded only
package adcdc_pkg;
  localparam int          ADCDC_NCH         = 2;
  localparam int          ADCDC_RES_W       = 24;
  localparam int          ADCDC_ACC_W       = 32;
  localparam int          ADCDC_RATE_W      = 3;
  localparam int          ADCDC_RATE_BIT    = 6;
  localparam logic [2:0]  ADCDC_RATE_RST    = 3'h2;
  localparam logic        ADCDC_CLKDIV_RST  = 1'b0;
  localparam logic        ADCDC_PDREF_RST   = 1'b1;
  localparam logic        ADCDC_VREFHI_RST  = 1'b0;
  localparam logic        ADCDC_CLKEN_RST   = 1'b0;
  localparam int          ADCDC_DIV_SLOW    = 4;
  localparam int          ADCDC_DIV_FAST    = 16;
  localparam int          ADCDC_FLT_ORDER   = 3;
  localparam int          ADCDC_SETTLE_EXTRA = 1;
  localparam int          ADCDC_SYS_HZ      = 20_000_000;
  localparam int          ADCDC_OSC_HZ      = 512_000;
  localparam int          ADCDC_OSC_HALF    = ADCDC_SYS_HZ / (2 * ADCDC_OSC_HZ);
  localparam logic [23:0] ADCDC_POS_FS      = 24'h7FFFFF;
  localparam logic [23:0] ADCDC_NEG_FS      = 24'h800000;
  localparam logic [23:0] ADCDC_MV_1V       = 24'h000FC2;
  localparam logic [23:0] ADCDC_MV_REF_HI   = 24'h000FC1;
  localparam logic [23:0] ADCDC_MV_REF_LO   = 24'h000974;

  typedef struct packed {
    logic       ref_high_level_select;
    logic       ref_buffer_power_down;
    logic       clk_out_enable;
  } adcdc_cfg2_s;

  typedef struct packed {
    logic [ADCDC_RES_W-1:0] ch1;
    logic [ADCDC_RES_W-1:0] ch0;
  } adcdc_word_s;

  typedef enum logic [1:0] {ADCDC_IDLE, ADCDC_SETTLE, ADCDC_RUN} adcdc_state_e;

  // decimation ratio from the output rate field: 2^(10-rate), 1024 down to 16
  function automatic logic [10:0] adcdc_ratio(input logic [2:0] rate);
    logic [10:0] r;
    r = 11'h400 >> ((rate > 3'h6) ? 3'h6 : rate);
    return r;
  endfunction : adcdc_ratio
endpackage : adcdc_pkg

/* File: sim/adcdc_chk.sv */
// port checker for the converter core
// assumes binding onto adcdc_core from the bench top
`timescale 1ns/1ps
module adcdc_chk
  import adcdc_pkg::*;
(
  input wire logic                           CLK_I,
  input wire logic                           RST_I,
  input wire logic                           CLOCK_SOURCE_SELECT_PIN_I,
  input wire logic                           CLK_PIN_OE_O,
  input wire adcdc_pkg::adcdc_cfg2_s         CFG2_I,
  input wire logic                           REF_HIGH_LEVEL_O,
  input wire logic                           REF_BUFFER_ON_O,
  input wire logic [23:0]                    REF_MV_O,
  input wire logic                           MOD_TICK_O,
  input wire logic                           RESULT_READY_STROBE_O,
  input wire logic [ADCDC_NCH*ADCDC_RES_W-1:0] RESULT_WORDS_O,
  input wire logic                           RESULT_VALID_O,
  input wire logic                           RESULT_READY_I,
  input wire logic                           OVERRUN_O,
  input wire logic                           CS_N_I,
  input wire logic                           DOUT_OE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_cs_idle;
    CS_N_I [*4];
  endsequence
  a_clk_oe_truth: assert property (
    CLK_PIN_OE_O == (CLOCK_SOURCE_SELECT_PIN_I & CFG2_I.clk_out_enable))
    else $error("clock pin enable wrong");
  a_ref_level: assert property (
    REF_HIGH_LEVEL_O == CFG2_I.ref_high_level_select && REF_MV_O ==
    (CFG2_I.ref_high_level_select ? ADCDC_MV_REF_HI : ADCDC_MV_REF_LO))
    else $error("reference level wrong");
  a_ref_buffer: assert property (REF_BUFFER_ON_O != CFG2_I.ref_buffer_power_down)
    else $error("reference buffer state wrong");
  a_dout_released: assert property (s_cs_idle |-> !DOUT_OE_O)
    else $error("data out driven while deselected");
  a_strobe_single: assert property (RESULT_READY_STROBE_O |=> !RESULT_READY_STROBE_O)
    else $error("ready strobe too long");
  a_tick_spacing: assert property (MOD_TICK_O |=> !MOD_TICK_O [*8])
    else $error("modulator ticks too close");
  a_overrun_full: assert property (OVERRUN_O |-> RESULT_VALID_O)
    else $error("overrun without stored results");
  a_head_held: assert property (
    RESULT_VALID_O && !RESULT_READY_I |=> RESULT_VALID_O && $stable(RESULT_WORDS_O))
    else $error("result head changed while stalled");
endmodule : adcdc_chk

/* File: sim/adcdc_decimation_clock_output_tb_top.sv */
// bench top for the converter core: clocks, stimulus and checks
// assumes adcdc_host as serial host and adcdc_chk bound below
`timescale 1ns/1ps
module adcdc_decimation_clock_output_tb_top;
  import adcdc_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, sel = 1'b0, ext_clk = 1'b0, rate_sel = 1'b0;
  logic        start = 1'b0, res_rdy = 1'b1;
  logic [2:0]  rate = 3'h6;
  logic [1:0]  mod_bit = 2'h3;
  adcdc_cfg2_s cfg = 3'h2;
  logic [47:0] words, rd;
  logic        clk_pin, clk_oe, ref_hi, ref_on, tick, strobe, valid, ovr, cs_n, sclk, dout, dout_oe;
  logic [23:0] ref_mv;
  int          err_count = 0, compares = 0, cyc = 0, ext_cnt = 0, n, t1, t2;
  adcdc_core i_dut (.CLK_I(clk), .RST_I(rst), .CLOCK_SOURCE_SELECT_PIN_I(sel), .EXT_CLK_I(ext_clk),
    .CLK_PIN_O(clk_pin), .CLK_PIN_OE_O(clk_oe), .CFG2_I(cfg), .CLK_RATE_SEL_I(rate_sel),
    .OUTPUT_RATE_FIELD_I(rate), .REF_HIGH_LEVEL_O(ref_hi), .REF_BUFFER_ON_O(ref_on),
    .REF_MV_O(ref_mv), .MOD_BIT_I(mod_bit), .START_I(start), .MOD_TICK_O(tick),
    .RESULT_READY_STROBE_O(strobe), .RESULT_WORDS_O(words), .RESULT_VALID_O(valid),
    .RESULT_READY_I(res_rdy), .OVERRUN_O(ovr), .CS_N_I(cs_n), .SCLK_I(sclk), .DOUT_O(dout),
    .DOUT_OE_O(dout_oe));
  adcdc_host i_host (.clk_i(clk), .dout_i(dout), .dout_oe_i(dout_oe), .cs_n_o(cs_n), .sclk_o(sclk));
  always #25 clk = ~clk;
  // master clock from a clock-master device, 40 or 10 cycles a period
  always @(negedge clk) begin
    ext_cnt = (ext_cnt + 1) % (rate_sel ? 5 : 20);
    if (ext_cnt == 0) ext_clk = ~ext_clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      err_count++;
      $display("[ERR] run length expected below %0d seen %0d", 95000, cyc);
      close_out();
    end
  end
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task automatic tick_gap(output int g);
    repeat (2) begin
      g = 0;
      do begin
        step(1);
        g++;
      end while (tick !== 1'b1 && g < 400);
    end
  endtask : tick_gap
  task automatic ticks_to_strobe(output int k);
    k = 0;
    do begin
      step(1);
      if (tick === 1'b1) k++;
    end while (strobe !== 1'b1 && k < 100);
  endtask : ticks_to_strobe
  task automatic pulse_start();
    @(negedge clk);
    start = 1'b0;
    repeat (200) @(negedge clk);
    start = 1'b1;
  endtask : pulse_start
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    step(1);
    chk("ref buffer at reset", 48'h0, 48'(ref_on));
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      {sel, cfg} = 4'(i);
      step(1);
      chk("clock pin oe", 48'(sel & cfg.clk_out_enable), 48'(clk_oe));
      chk("ref mv", 48'(cfg.ref_high_level_select ? ADCDC_MV_REF_HI : ADCDC_MV_REF_LO),
          48'(ref_mv));
      chk("ref high level", 48'(cfg.ref_high_level_select), 48'(ref_hi));
      chk("clock pin idle", 48'h0, 48'(clk_pin & ~(sel & cfg.clk_out_enable)));
      chk("ref buffer", 48'(!cfg.ref_buffer_power_down), 48'(ref_on));
    end
    @(negedge clk);
    {sel, cfg} = 4'h2;
    $display("test clock and reference done");
    tick_gap(n);
    chk("tick gap slow", 48'(ADCDC_DIV_SLOW * 40), 48'(n));
    @(negedge clk);
    rate_sel = 1'b1;
    tick_gap(n);
    tick_gap(n);
    chk("tick gap fast", 48'(ADCDC_DIV_FAST * 10), 48'(n));
    $display("test modulator clock done");
    @(negedge clk);
    res_rdy = 1'b0;
    pulse_start();
    ticks_to_strobe(t1);
    // three decimations discarded, first result on the fourth, one tick of start jitter
    chk("start settle", 48'h1, 48'(t1 >= 4 * 16 && t1 <= 4 * 16 + 1));
    ticks_to_strobe(n);
    chk("ticks per result", 48'(1024 >> rate), 48'(n));
    pulse_start();
    ticks_to_strobe(t2);
    chk("start delay repeat", 48'h1, 48'(t1 - t2 <= 1 && t2 - t1 <= 1));
    chk("result head", {ADCDC_POS_FS, ADCDC_POS_FS}, words);
    $display("test start and settling done");
    n = 0;
    while (ovr !== 1'b1 && n < 60000) begin
      step(1);
      n++;
    end
    chk("overrun while full", 48'h1, 48'(valid & ovr));
    @(negedge clk);
    res_rdy = 1'b1;
    n = 0;
    while (valid === 1'b1 && n < 40) begin
      chk("drained word", {ADCDC_POS_FS, ADCDC_POS_FS}, words);
      n++;
      step(1);
    end
    chk("fifo depth", 48'h10, 48'(n));
    $display("test buffer done");
    i_host.read_frame(rd);
    chk("serial frame", {ADCDC_POS_FS, ADCDC_POS_FS}, rd);
    step(6);
    chk("dout released", 48'h0, 48'(dout_oe));
    $display("test serial read done");
    close_out();
  end
endmodule : adcdc_decimation_clock_output_tb_top
bind adcdc_core adcdc_chk i_chk (.CLK_I, .RST_I, .CLOCK_SOURCE_SELECT_PIN_I, .CLK_PIN_OE_O, .CFG2_I,
  .REF_HIGH_LEVEL_O, .REF_BUFFER_ON_O, .REF_MV_O, .MOD_TICK_O, .RESULT_READY_STROBE_O,
  .RESULT_WORDS_O, .RESULT_VALID_O, .RESULT_READY_I, .OVERRUN_O, .CS_N_I, .DOUT_OE_O);

/* File: sim/adcdc_host.sv */
// serial host model: selects the core and clocks one 48-bit frame out
// assumes the bench clock; a released line reads the inverse of its last bit
`timescale 1ns/1ps
module adcdc_host (
  input  wire logic clk_i,
  input  wire logic dout_i,
  input  wire logic dout_oe_i,
  output logic      cs_n_o,
  output logic      sclk_o
);
  logic last = 1'b0;
  logic line;
  initial cs_n_o = 1'b1;
  initial sclk_o = 1'b0;
  assign line = dout_oe_i ? dout_i : ~last;
  always @(posedge clk_i) if (dout_oe_i) last <= dout_i;
  task automatic read_frame(output logic [47:0] d);
    @(negedge clk_i);
    cs_n_o = 1'b0;
    repeat (20) @(negedge clk_i);
    for (int b = 47; b >= 0; b--) begin
      sclk_o = 1'b1;
      d[b] = line;
      repeat (20) @(negedge clk_i);
      sclk_o = 1'b0;
      repeat (20) @(negedge clk_i);
    end
    cs_n_o = 1'b1;
  endtask : read_frame
endmodule : adcdc_host
